// [verilog/jtbs_defines.svh]
`ifndef JTBS_DEFINES_SVH
`define JTBS_DEFINES_SVH

`define JTBS_IR_WIDTH 4
`define JTBS_IR_CAPTURE 4'h1
`define JTBS_OP_EXTEST 4'h0
`define JTBS_OP_SAMPLE 4'h3
`define JTBS_OP_CLAMP 4'h5
`define JTBS_OP_HIGHZ 4'h7
`define JTBS_OP_CLAMP_OFF 4'h9
`define JTBS_OP_INTEST 4'hC
`define JTBS_OP_IDCODE 4'hE
`define JTBS_OP_BYPASS 4'hF
`define JTBS_CHAIN_SEL_WIDTH 4
`define JTBS_CHAIN_SEL_RESET 4'h3
`define JTBS_ID_WIDTH 32
`define JTBS_TLR_ONES 5

`endif

// [verilog/jtbs_pkg.sv]
package jtbs_pkg;
  // tap states, gray coded along the common walk
  typedef enum logic [3:0] {
    JTBS_TLR = 4'h0,
    JTBS_RTI = 4'h1,
    JTBS_SEL_DR = 4'h3,
    JTBS_CAP_DR = 4'h2,
    JTBS_SHIFT_DR = 4'h6,
    JTBS_EXIT1_DR = 4'h7,
    JTBS_PAUSE_DR = 4'h5,
    JTBS_EXIT2_DR = 4'h4,
    JTBS_UPD_DR = 4'hC,
    JTBS_SEL_IR = 4'hD,
    JTBS_CAP_IR = 4'hF,
    JTBS_SHIFT_IR = 4'hE,
    JTBS_EXIT1_IR = 4'hA,
    JTBS_PAUSE_IR = 4'hB,
    JTBS_EXIT2_IR = 4'h9,
    JTBS_UPD_IR = 4'h8
  } jtbs_state_t;

  typedef enum logic [1:0] {
    JTBS_PATH_BYPASS = 2'h0,
    JTBS_PATH_CHAIN = 2'h1,
    JTBS_PATH_ID = 2'h2,
    JTBS_PATH_SEL = 2'h3
  } jtbs_path_t;
endpackage

// [verilog/jtbs_sync.sv]
// two-stage synchroniser for a bundle of pin levels
module jtbs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } jtbs_sync_state_t;

  jtbs_sync_state_t state;
  jtbs_sync_state_t next_state;

  always_comb begin
    next_state.meta = d_i;
    next_state.sync = state.meta;
    if (!rst_n_i) begin
      next_state = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    state <= next_state;
  end

  assign q_o = state.sync;
endmodule // jtbs_sync

// [verilog/jtbs_cell_chain.sv]
// boundary cells: shift stage, update latch and pad/core muxing
module jtbs_cell_chain
  import jtbs_pkg::*;
#(
  parameter int N_IN = 4,
  parameter int N_OUT = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic capture_i,
  input wire logic shift_i,
  input wire logic update_i,
  input wire logic test_mode_i,
  input wire logic intest_i,
  input wire logic outputs_off_i,
  input wire logic clamp_i,
  input wire logic tdi_i,
  input wire logic [N_IN-1:0] pad_in_i,
  input wire logic [N_OUT-1:0] core_out_i,
  input wire logic [N_OUT-1:0] core_oe_i,
  output logic [N_IN-1:0] core_in_o,
  output logic [N_OUT-1:0] pad_out_o,
  output logic [N_OUT-1:0] pad_oe_o,
  output logic serial_o
);
  localparam int LEN = N_IN + 2 * N_OUT;

  typedef struct packed {
    logic [LEN-1:0] shift;
    logic [LEN-1:0] latch;
  } jtbs_chain_state_t;

  jtbs_chain_state_t state;
  jtbs_chain_state_t next_state;
  logic [LEN-1:0] parallel;

  // chain order from tdi: inputs, output data, output enables; bit 0 is nearest tdo
  always_comb begin
    // intest observes the core side: inverted core inputs, true core outputs
    if (intest_i) begin
      parallel = {~core_in_o, core_out_i, core_oe_i};
    end else begin
      parallel = {pad_in_i, pad_out_o, pad_oe_o};
    end
    next_state = state;
    if (capture_i) begin
      next_state.shift = parallel;
    end else if (shift_i) begin
      next_state.shift = {tdi_i, state.shift[LEN-1:1]};
    end
    if (update_i) begin
      next_state.latch = state.shift;
    end
    if (!rst_n_i) begin
      next_state = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    state <= next_state;
  end

  assign serial_o = state.shift[0];
  // latched values reach core only in test mode, pads also in clamp, highz and clamp-off; sample keeps system mode
  assign core_in_o = test_mode_i ? state.latch[LEN-1 -: N_IN] : pad_in_i;
  assign pad_out_o = (test_mode_i || clamp_i || outputs_off_i)
    ? state.latch[2*N_OUT-1 -: N_OUT] : core_out_i;
  assign pad_oe_o = outputs_off_i ? '0
    : (test_mode_i || clamp_i) ? state.latch[N_OUT-1:0] : core_oe_i;
endmodule // jtbs_cell_chain

// [verilog/jtbs_tap.sv]
// Functional notes
// - protocol uses only tdi, tms, tck, trst_n and tdo pins.
// - reset selects system mode; cells never intercept pads or core.
// - chain select resets to 0011; other values disable boundary work.
// - instruction register is four bits, no parity.
// - capture-ir loads 0001 into instruction shift stage.
// - extest 0000, sample 0011, intest 1100 put chain on tdi-tdo.
// - clamp 0101, highz 0111, clamp-off 1001 put bypass on tdi-tdo.
// - tdi/tms sampled on tck rise; tdo changes on tck fall.
// - boundary cells intercept every connection, linked into one serial register.
// - extest puts all cells in test mode, chain on path.
// - extest capture loads input pins and driven output values.
// - extest shift moves chain out tdo, tdi in.
// - extest update copies shift stage to latches, applied immediately.
// - sample keeps system mode; capture snapshots cell signals.
// - sample update fills latches without reaching pins or core.
// - clamp drives output pins from latched boundary values.
// - highz turns every output driver off.
// - clamp-off disables drivers while data still comes from cells.
// - intest capture takes inverted inputs and true core outputs.
// - idcode puts 32-bit id register on path; capture loads code.
// - code 1111 selects bypass, cells in system mode.
`include "jtbs_defines.svh"

module jtbs_tap
  import jtbs_pkg::*;
#(
  parameter int N_IN = 4,
  parameter int N_OUT = 4,
  parameter logic [`JTBS_ID_WIDTH-1:0] ID_CODE = 32'h0000_0001  // arbitrary value
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  input wire logic [N_IN-1:0] pad_in_i,
  input wire logic [N_OUT-1:0] core_out_i,
  input wire logic [N_OUT-1:0] core_oe_i,
  output logic [N_IN-1:0] core_in_o,
  output logic [N_OUT-1:0] pad_out_o,
  output logic [N_OUT-1:0] pad_oe_o,
  output logic tap_reset_o
);
  typedef struct packed {
    logic tck_d;
    jtbs_state_t fsm;
    logic [`JTBS_IR_WIDTH-1:0] ir_shift;
    logic [`JTBS_IR_WIDTH-1:0] ir;
    logic [`JTBS_CHAIN_SEL_WIDTH-1:0] sel_shift;
    logic [`JTBS_CHAIN_SEL_WIDTH-1:0] chain_sel;
    logic [`JTBS_ID_WIDTH-1:0] id_shift;
    logic bypass;
    logic tdo;
    logic tdo_oe;
  } jtbs_tap_state_t;

  jtbs_tap_state_t state;
  jtbs_tap_state_t next_state;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic trst_n_s;
  logic rise;
  logic fall;
  logic chain_ok;
  logic is_extest;
  logic is_sample;
  logic is_intest;
  logic on_chain;
  jtbs_path_t path;
  logic cap_dr;
  logic sh_dr;
  logic upd_dr;
  logic cell_out;
  logic serial_bit;

  // pins cross into sys_clk through two flops each
  jtbs_sync #(.WIDTH(4)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .d_i({tck_i, tms_i, tdi_i, trst_n_i}),
    .q_o({tck_s, tms_s, tdi_s, trst_n_s})
  );

  assign rise = tck_s && !state.tck_d;
  assign fall = !tck_s && state.tck_d;

  // chain select must hold 0011 for any boundary instruction to act
  assign chain_ok = (state.chain_sel == `JTBS_CHAIN_SEL_RESET);
  assign is_extest = chain_ok && (state.ir == `JTBS_OP_EXTEST);
  assign is_sample = chain_ok && (state.ir == `JTBS_OP_SAMPLE);
  assign is_intest = chain_ok && (state.ir == `JTBS_OP_INTEST);
  assign on_chain = is_extest || is_sample || is_intest;

  always_comb begin
    if (on_chain) begin
      path = JTBS_PATH_CHAIN;
    end else if (state.ir == `JTBS_OP_IDCODE) begin
      path = JTBS_PATH_ID;
    end else if (state.ir == `JTBS_OP_SAMPLE || state.ir == `JTBS_OP_EXTEST
        || state.ir == `JTBS_OP_INTEST) begin
      path = JTBS_PATH_SEL;
    end else begin
      path = JTBS_PATH_BYPASS;
    end
  end

  assign cap_dr = rise && state.fsm == JTBS_CAP_DR;
  assign sh_dr = rise && state.fsm == JTBS_SHIFT_DR;
  assign upd_dr = rise && state.fsm == JTBS_UPD_DR;

  jtbs_cell_chain #(.N_IN(N_IN), .N_OUT(N_OUT)) u_chain (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .capture_i(cap_dr && on_chain),
    .shift_i(sh_dr && on_chain),
    .update_i(upd_dr && on_chain),
    .test_mode_i(is_extest || is_intest),
    .intest_i(is_intest),
    .outputs_off_i(chain_ok && (state.ir == `JTBS_OP_HIGHZ
      || state.ir == `JTBS_OP_CLAMP_OFF)),
    .clamp_i(chain_ok && state.ir == `JTBS_OP_CLAMP),
    .tdi_i(tdi_s),
    .pad_in_i(pad_in_i),
    .core_out_i(core_out_i),
    .core_oe_i(core_oe_i),
    .core_in_o(core_in_o),
    .pad_out_o(pad_out_o),
    .pad_oe_o(pad_oe_o),
    .serial_o(cell_out)
  );

  always_comb begin
    unique case (path)
      JTBS_PATH_CHAIN: serial_bit = cell_out;
      JTBS_PATH_ID: serial_bit = state.id_shift[0];
      JTBS_PATH_SEL: serial_bit = state.sel_shift[0];
      JTBS_PATH_BYPASS: serial_bit = state.bypass;
    endcase
  end

  always_comb begin
    next_state = state;
    next_state.tck_d = tck_s;
    if (rise) begin
      unique case (state.fsm)
        JTBS_TLR: next_state.fsm = tms_s ? JTBS_TLR : JTBS_RTI;
        JTBS_RTI: next_state.fsm = tms_s ? JTBS_SEL_DR : JTBS_RTI;
        JTBS_SEL_DR: next_state.fsm = tms_s ? JTBS_SEL_IR : JTBS_CAP_DR;
        JTBS_CAP_DR: next_state.fsm = tms_s ? JTBS_EXIT1_DR : JTBS_SHIFT_DR;
        JTBS_SHIFT_DR: next_state.fsm = tms_s ? JTBS_EXIT1_DR : JTBS_SHIFT_DR;
        JTBS_EXIT1_DR: next_state.fsm = tms_s ? JTBS_UPD_DR : JTBS_PAUSE_DR;
        JTBS_PAUSE_DR: next_state.fsm = tms_s ? JTBS_EXIT2_DR : JTBS_PAUSE_DR;
        JTBS_EXIT2_DR: next_state.fsm = tms_s ? JTBS_UPD_DR : JTBS_SHIFT_DR;
        JTBS_UPD_DR: next_state.fsm = tms_s ? JTBS_SEL_DR : JTBS_RTI;
        JTBS_SEL_IR: next_state.fsm = tms_s ? JTBS_TLR : JTBS_CAP_IR;
        JTBS_CAP_IR: next_state.fsm = tms_s ? JTBS_EXIT1_IR : JTBS_SHIFT_IR;
        JTBS_SHIFT_IR: next_state.fsm = tms_s ? JTBS_EXIT1_IR : JTBS_SHIFT_IR;
        JTBS_EXIT1_IR: next_state.fsm = tms_s ? JTBS_UPD_IR : JTBS_PAUSE_IR;
        JTBS_PAUSE_IR: next_state.fsm = tms_s ? JTBS_EXIT2_IR : JTBS_PAUSE_IR;
        JTBS_EXIT2_IR: next_state.fsm = tms_s ? JTBS_UPD_IR : JTBS_SHIFT_IR;
        JTBS_UPD_IR: next_state.fsm = tms_s ? JTBS_SEL_DR : JTBS_RTI;
      endcase
      unique case (state.fsm)
        JTBS_CAP_IR: next_state.ir_shift = `JTBS_IR_CAPTURE;
        JTBS_SHIFT_IR: next_state.ir_shift = {tdi_s, state.ir_shift[`JTBS_IR_WIDTH-1:1]};
        JTBS_UPD_IR: next_state.ir = state.ir_shift;
        JTBS_CAP_DR: begin
          next_state.bypass = 1'b0;
          next_state.id_shift = ID_CODE;
          next_state.sel_shift = state.chain_sel;
        end
        JTBS_SHIFT_DR: begin
          unique case (path)
            JTBS_PATH_ID: next_state.id_shift = {tdi_s, state.id_shift[`JTBS_ID_WIDTH-1:1]};
            JTBS_PATH_SEL:
              next_state.sel_shift = {tdi_s, state.sel_shift[`JTBS_CHAIN_SEL_WIDTH-1:1]};
            JTBS_PATH_BYPASS: next_state.bypass = tdi_s;
            JTBS_PATH_CHAIN: next_state.bypass = state.bypass;
          endcase
        end
        JTBS_UPD_DR: begin
          if (path == JTBS_PATH_SEL) begin
            next_state.chain_sel = state.sel_shift;
          end
        end
        default: next_state.bypass = state.bypass;
      endcase
    end
    if (fall) begin
      next_state.tdo_oe = (state.fsm == JTBS_SHIFT_DR) || (state.fsm == JTBS_SHIFT_IR);
      next_state.tdo = (state.fsm == JTBS_SHIFT_IR) ? state.ir_shift[0] : serial_bit;
    end
    // any reset returns to identification and system mode
    if (!rst_n_i || !trst_n_s || state.fsm == JTBS_TLR) begin
      next_state.ir = `JTBS_OP_IDCODE;
      next_state.chain_sel = `JTBS_CHAIN_SEL_RESET;
    end
    if (!rst_n_i || !trst_n_s) begin
      next_state.fsm = JTBS_TLR;
      next_state.tdo = 1'b0;
      next_state.tdo_oe = 1'b0;
      next_state.ir_shift = `JTBS_IR_CAPTURE;
    end
    if (!rst_n_i) begin
      next_state = '0;
      next_state.ir = `JTBS_OP_IDCODE;
      next_state.chain_sel = `JTBS_CHAIN_SEL_RESET;
      next_state.ir_shift = `JTBS_IR_CAPTURE;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    state <= next_state;
  end

  assign tdo_o = state.tdo;
  assign tdo_oe_o = state.tdo_oe;
  assign tap_reset_o = (state.fsm == JTBS_TLR);
endmodule // jtbs_tap

// [test/jtbs_tester.sv]
// board tester side: drives tck, tms, tdi, trst_n and reads tdo
module jtbs_tester (
  input wire logic sys_clk_i,
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    trst_n_o = 1'b1;
  end
  // one tck period, four sys_clk low then four high; tck stands low between calls
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o <= tms;
    tdi_o <= tdi;
    repeat (4) @(posedge sys_clk_i);
    tck_o <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    tdo = tdo_i;
    @(posedge sys_clk_i);
    tck_o <= 1'b0;
  endtask
endmodule  // jtbs_tester

// [test/jtbs_tap_checker.sv]
module jtbs_tap_checker #(
  parameter int N_IN = 4,
  parameter int N_OUT = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic trst_n_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  input wire logic [N_IN-1:0] pad_in_i,
  input wire logic [N_OUT-1:0] core_out_i,
  input wire logic [N_OUT-1:0] core_oe_i,
  input wire logic [N_IN-1:0] core_in_o,
  input wire logic [N_OUT-1:0] pad_out_o,
  input wire logic [N_OUT-1:0] pad_oe_o,
  input wire logic tap_reset_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic tck_d = 1'b0;
  logic [2:0] ones;
  // run of tck rises seen with tms high
  always_ff @(posedge sys_clk_i) begin
    tck_d <= tck_i;
    if (!rst_n_i || (tck_i && !tck_d && !tms_i)) begin
      ones <= 3'h0;
    end else if (tck_i && !tck_d && ones != 3'h7) begin
      ones <= ones + 3'h1;
    end
  end
  chk_tdo_on_fall: assert property ($changed(tdo_o) |-> !tck_i && !$past(tck_i, 2))
    else $error("tdo moved outside the tck low phase");
  chk_oe_on_fall: assert property ($changed(tdo_oe_o) |-> !tck_i && !$past(tck_i, 2))
    else $error("tdo enable moved outside the tck low phase");
  chk_trst_reset: assert property (!trst_n_i [*4] |=> tap_reset_o)
    else $error("held test reset did not reset the tap");
  chk_reset_state: assert property ($rose(rst_n_i) |-> tap_reset_o && !tdo_oe_o && !tdo_o)
    else $error("wrong state after reset");
  chk_reset_pads: assert property (tap_reset_o [*2] |-> pad_out_o == core_out_i
    && pad_oe_o == core_oe_i)
    else $error("pads intercepted in reset");
  chk_reset_core: assert property (tap_reset_o [*2] |-> core_in_o == pad_in_i)
    else $error("core inputs intercepted in reset");
  chk_reset_quiet: assert property (tap_reset_o [*2] |-> !tdo_oe_o)
    else $error("tdo driven in reset state");
  chk_five_ones: assert property (ones == 3'h5 && $past(ones) == 3'h4 |-> ##[0:8] tap_reset_o)
    else $error("five tms-high cycles did not reach reset");
endmodule  // jtbs_tap_checker

bind jtbs_tap jtbs_tap_checker #(.N_IN(N_IN), .N_OUT(N_OUT)) jtbs_tap_checker_inst (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .tck_i(tck_i), .tms_i(tms_i),
  .trst_n_i(trst_n_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .pad_in_i(pad_in_i),
  .core_out_i(core_out_i), .core_oe_i(core_oe_i), .core_in_o(core_in_o),
  .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .tap_reset_o(tap_reset_o));

// [test/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ID = 32'h5A3C_0F01;  // arbitrary
  localparam logic [15:0] CODES = 16'hF975;
  localparam logic [15:0] EXP_OUT = 16'h6999;
  localparam logic [15:0] EXP_OE = 16'h300C;
  logic sys_clk, rst_n, tck, tms, tdi, trst_n, tdo, tdo_oe, tap_reset, tdo_line;
  logic [3:0] pad_in, core_out, core_oe, core_in, pad_out, pad_oe;
  logic [31:0] got;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;
  jtbs_tap #(.N_IN(4), .N_OUT(4), .ID_CODE(ID)) jtbs_tap_inst (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_n_i(trst_n), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pad_in_i(pad_in),
    .core_out_i(core_out), .core_oe_i(core_oe), .core_in_o(core_in),
    .pad_out_o(pad_out), .pad_oe_o(pad_oe), .tap_reset_o(tap_reset));
  jtbs_tester jtbs_tester_inst (.sys_clk_i(sys_clk), .tdo_i(tdo_line), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n));
  // released tdo shows the inverse of its last level
  assign tdo_line = tdo_oe ? tdo : ~tdo;
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic final_report();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic st(input logic m, input logic d);
    logic b;
    jtbs_tester_inst.step(m, d, b);
  endtask
  // from run-test-idle through capture, shift, update and back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic b;
    dout = '0;
    st(1'b1, 1'b0);
    if (ir) begin
      st(1'b1, 1'b0);
    end
    st(1'b0, 1'b0);
    st(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      jtbs_tester_inst.step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    st(1'b1, 1'b0);
    st(1'b0, 1'b0);
  endtask
  task automatic load_ir(input logic [3:0] code);
    scan(1'b1, 4, {28'h0, code}, got);
    chk("ir capture", 32'h1, got);
  endtask
  task automatic pins(input logic [3:0] po, input logic [3:0] oe, input logic [3:0] ci);
    chk("pad out", po, pad_out);
    chk("pad oe", oe, pad_oe);
    chk("core in", ci, core_in);
  endtask
  task automatic t_reset();
    chk("tap reset", 32'h1, tap_reset);
    pins(4'h6, 4'h3, 4'hA);
    st(1'b0, 1'b0);
    scan(1'b0, 32, 32'h0, got);
    chk("id code", ID, got);
    $display("test reset done");
  endtask
  task automatic t_sample();
    load_ir(4'h3);
    scan(1'b0, 12, 32'h59C, got);
    chk("sample capture", 32'hA63, got);
    pins(4'h6, 4'h3, 4'hA);
    $display("test sample done");
  endtask
  task automatic t_bypass();
    for (int i = 0; i < 4; i++) begin
      load_ir(CODES[4*i +: 4]);
      scan(1'b0, 8, 32'hB5, got);
      chk("bypass shift", 32'h6A, got);
      pins(EXP_OUT[4*i +: 4], EXP_OE[4*i +: 4], 4'hA);
    end
    $display("test bypass done");
  endtask
  task automatic t_extest();
    load_ir(4'h0);
    pins(4'h9, 4'hC, 4'h5);
    scan(1'b0, 12, 32'h3A5, got);
    chk("extest capture", 32'hA9C, got);
    pins(4'hA, 4'h5, 4'h3);
    $display("test extest done");
  endtask
  task automatic t_intest();
    load_ir(4'hC);
    scan(1'b0, 12, 32'h0, got);
    chk("intest capture", 32'hC63, got);
    pins(4'h0, 4'h0, 4'h0);
    $display("test intest done");
  endtask
  task automatic t_tlr();
    chk("run state", 32'h0, tap_reset);
    jtbs_tester_inst.trst_n_o <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk("trst reset", 32'h1, tap_reset);
    pins(4'h6, 4'h3, 4'hA);
    jtbs_tester_inst.trst_n_o <= 1'b1;
    repeat (4) @(posedge sys_clk);
    st(1'b0, 1'b0);
    load_ir(4'hF);
    repeat (5) st(1'b1, 1'b0);
    repeat (4) @(posedge sys_clk);
    chk("five ones reset", 32'h1, tap_reset);
    st(1'b0, 1'b0);
    scan(1'b0, 32, 32'h0, got);
    chk("id after reset", ID, got);
    $display("test tlr done");
  endtask
  initial begin
    rst_n = 1'b0;
    pad_in = 4'hA;
    core_out = 4'h6;
    core_oe = 4'h3;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_sample();
    t_bypass();
    t_extest();
    t_intest();
    t_tlr();
    final_report();
  end
endmodule  // tb
